// ===== design/shift_latch_pkg.sv
// shared types and constants for the serial-to-parallel latch
package shift_latch_pkg;
  localparam int STAGE_COUNT = 8;
  localparam int SYNC_DEPTH = 2;
  localparam int FIFO_DEPTH = 4;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  localparam logic [7:0] STORE_RESET = 8'h00;
  // pin group from the host, sampled by mclk
  typedef struct packed {
    logic shift_clock;
    logic store_clock;
    logic shift_clear_n;
    logic shift_data_in;
    logic output_enable_n;
  } pin_in_type;
endpackage

// ===== design/snapshot_fifo.sv
// small fifo carrying storage snapshots toward the parallel outputs
`timescale 1ns/1ps
module snapshot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // write side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // read side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] count;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
  } fifo_state_type;
  fifo_state_type state;
  fifo_state_type next_state;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;

  // honest flags straight from the occupancy count
  assign in_ready = (state.count != (AW+1)'(DEPTH));
  assign out_valid = (state.count != '0);
  assign out_data = mem[state.rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // pointer and count update
  always_comb begin
    next_state = state;
    if (do_wr) begin
      next_state.wr_ptr = (state.wr_ptr == AW'(DEPTH-1)) ? '0 : state.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_state.rd_ptr = (state.rd_ptr == AW'(DEPTH-1)) ? '0 : state.rd_ptr + 1'b1;
    end
    next_state.count = state.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // storage array carries no reset
  always_ff @(posedge mclk) begin
    if (do_wr) begin
      mem[state.wr_ptr] <= in_data;
    end
  end
endmodule

// ===== design/serial_to_parallel_latch_8bit.sv
// serial-in shift register feeding a storage register with three-state outputs
//
// Summary of operation
// - eight-stage serial shift register, copied into a separate eight-bit storage register
// - storage register drives eight parallel outputs that can drive high, low or float
// - shift and storage registers each have their own clock input
// - clear forces all shift stages to zero, overriding any shift
// - clear input is active low; high lets shifting proceed
// - shift register advances one stage per shift clock rising edge
// - storage clock rising edge copies the eight shift bits into storage
// - last shift stage is always driven on the cascade output
// - enable high floats all parallel outputs; low drives storage contents
// - enable touches only parallel drivers, never registers or cascade output
// - first stage takes serial input, others take the preceding stage's old value
// - clocks rising together: storage gets pre-edge shift contents, then shift occurs
// - register contents have no defined power-up value until cleared or loaded; here sys_rst loads zeros into both registers
`timescale 1ns/1ps
module serial_to_parallel_latch_8bit
  import shift_latch_pkg::*;
#(
  parameter int WIDTH = STAGE_COUNT,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // host pins, asynchronous to mclk
  input wire logic shift_data_in,
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic store_clock,
  input wire logic output_enable_n,
  // parallel outputs, two signals per pin
  output logic [WIDTH-1:0] parallel_out,
  output logic [WIDTH-1:0] parallel_out_oe_n,
  // cascade output
  output logic cascade_out
);
  typedef struct packed {
    pin_in_type sync1;
    pin_in_type sync2;
    logic shift_clock_d;
    logic store_clock_d;
    logic [WIDTH-1:0] shift_reg;
    logic [WIDTH-1:0] store_reg;
    logic pend_valid;
    logic [WIDTH-1:0] pend_data;
    logic [WIDTH-1:0] drive_data;
    logic [WIDTH-1:0] drive_oe_n;
    logic cascade;
  } latch_state_type;

  latch_state_type state;
  latch_state_type next_state;
  pin_in_type pins;
  logic shift_rise;
  logic store_rise;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WIDTH-1:0] fifo_out_data;

  // pack pins so the synchroniser treats them as one group
  assign pins.shift_clock = shift_clock;
  assign pins.store_clock = store_clock;
  assign pins.shift_clear_n = shift_clear_n;
  assign pins.shift_data_in = shift_data_in;
  assign pins.output_enable_n = output_enable_n;

  // edges found only on the second synchroniser stage
  assign shift_rise = state.sync2.shift_clock && !state.shift_clock_d;
  assign store_rise = state.sync2.store_clock && !state.store_clock_d;

  // storage snapshots queue here before reaching the drivers
  snapshot_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(state.pend_valid),
    .in_ready(fifo_in_ready),
    .in_data(state.pend_data),
    .out_valid(fifo_out_valid),
    .out_ready(1'b1),
    .out_data(fifo_out_data)
  );

  // next-state logic for the whole block
  always_comb begin
    next_state = state;
    next_state.sync1 = pins;
    next_state.sync2 = state.sync1;
    next_state.shift_clock_d = state.sync2.shift_clock;
    next_state.store_clock_d = state.sync2.store_clock;
    // storage samples the old shift contents, so a shared edge sees pre-shift data
    if (store_rise) begin
      next_state.store_reg = state.shift_reg;
    end
    // clear holds the shift stages at zero for as long as it is low
    if (!state.sync2.shift_clear_n) begin
      next_state.shift_reg = '0;
    end else if (shift_rise) begin
      next_state.shift_reg = {state.shift_reg[WIDTH-2:0], state.sync2.shift_data_in};
    end
    // hand a new snapshot to the fifo; holds if the fifo is full
    if (state.pend_valid && fifo_in_ready) begin
      next_state.pend_valid = 1'b0;
    end
    if (store_rise) begin
      next_state.pend_valid = 1'b1;
      next_state.pend_data = state.shift_reg;
    end
    if (fifo_out_valid) begin
      next_state.drive_data = fifo_out_data;
    end
    // enable only steers the drivers, no register depends on it
    next_state.drive_oe_n = {WIDTH{state.sync2.output_enable_n}};
    next_state.cascade = next_state.shift_reg[WIDTH-1];
  end

  // sys_rst stands in for the unknown power-up state, giving zeros
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= '0;
      state.sync1.shift_clear_n <= 1'b1;
      state.sync2.shift_clear_n <= 1'b1;
      state.sync1.output_enable_n <= 1'b1;
      state.sync2.output_enable_n <= 1'b1;
      state.drive_oe_n <= '1;
      // named reset values stand in for the undefined power-up contents
      state.shift_reg <= WIDTH'(SHIFT_RESET);
      state.store_reg <= WIDTH'(STORE_RESET);
    end else begin
      state <= next_state;
    end
  end

  // outputs straight from flip-flops
  assign parallel_out = state.drive_data;
  assign parallel_out_oe_n = state.drive_oe_n;
  assign cascade_out = state.cascade;
endmodule

// ===== test/latch_properties.sv
// port checker for the serial-to-parallel latch
`timescale 1ns/1ps
module latch_properties #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // host pins
  input wire logic shift_data_in,
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic store_clock,
  input wire logic output_enable_n,
  // outputs
  input wire logic [WIDTH-1:0] parallel_out,
  input wire logic [WIDTH-1:0] parallel_out_oe_n,
  input wire logic cascade_out
);
  logic [2:0] age;
  // cycles since reset; the synchronisers still carry stale pins at first
  always_ff @(posedge mclk) age <= sys_rst ? 3'h0 : age + {2'h0, age != 3'h7};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst || age != 3'h7);
  sequence shift_seen;
    $past(shift_clock, 3) && !$past(shift_clock, 4);
  endsequence
  sequence store_seen;
    $past(store_clock, 5) && !$past(store_clock, 6);
  endsequence
  AST_OE_TRACK: assert property (parallel_out_oe_n == {WIDTH{$past(output_enable_n, 3)}})
    else $error("enable did not follow its pin");
  AST_OE_SAME: assert property (&parallel_out_oe_n || !(|parallel_out_oe_n))
    else $error("output enables split");
  AST_OE_STEADY: assert property ($stable(output_enable_n) [*4] |-> $stable(parallel_out_oe_n))
    else $error("enable moved without cause");
  AST_CLEAR_ZERO: assert property (!$past(shift_clear_n, 3) |-> !cascade_out)
    else $error("clear did not zero cascade");
  AST_CLEAR_HELD: assert property ((!shift_clear_n) [*4] |=> !cascade_out [*2])
    else $error("shift overrode clear");
  AST_CASCADE_CAUSE: assert property ($changed(cascade_out) |-> shift_seen or !$past(shift_clear_n, 3))
    else $error("cascade moved without shift");
  AST_PAR_CAUSE: assert property ($changed(parallel_out) |-> store_seen)
    else $error("outputs moved without store");
  AST_RESET_STATE: assert property (disable iff (1'b0)
    $fell(sys_rst) |-> parallel_out == '0 && &parallel_out_oe_n && !cascade_out)
    else $error("bad state after reset");
endmodule

// ===== test/host_model.sv
// host model driving the latch pins on mclk falling edges
`timescale 1ns/1ps
module host_model (
  // clock
  input wire logic mclk,
  // pins toward the latch
  output logic shift_data_in,
  output logic shift_clock,
  output logic shift_clear_n,
  output logic store_clock,
  output logic output_enable_n
);
  // idle pins; clear high lets shifting run
  initial begin
    {shift_data_in, shift_clock, store_clock} = 3'h0;
    shift_clear_n = 1'b1;
    output_enable_n = 1'b1;
  end
  // one 320 ns link period, clocks still low between frames
  task automatic pulse(input logic sh, input logic st);
    repeat (4) @(negedge mclk);
    shift_clock = sh;
    store_clock = st;
    repeat (4) @(negedge mclk);
    {shift_clock, store_clock} = 2'h0;
  endtask
  // msb first, so the first bit ends in the last stage; data inverts once released
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      @(negedge mclk);
      shift_data_in = v[i];
      pulse(1'b1, 1'b0);
    end
    shift_data_in = ~v[0];
  endtask
endmodule

// ===== test/serial_to_parallel_latch_8bit_tb.sv
// bench for the serial-to-parallel latch
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module serial_to_parallel_latch_8bit_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic sdi, sck, clr_n, stc, oe_n, cas;
  logic [7:0] pout, poe_n;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [8:0] rows [4] = '{9'h0a5, 9'h1ff, 9'h000, 9'h13c}; // {oe_n, byte}
  host_model u_host (.mclk(mclk), .shift_data_in(sdi), .shift_clock(sck),
    .shift_clear_n(clr_n), .store_clock(stc), .output_enable_n(oe_n));
  serial_to_parallel_latch_8bit u_dut (.mclk(mclk), .sys_rst(sys_rst), .shift_data_in(sdi),
    .shift_clock(sck), .shift_clear_n(clr_n), .store_clock(stc), .output_enable_n(oe_n),
    .parallel_out(pout), .parallel_out_oe_n(poe_n), .cascade_out(cas));
  initial forever #20 mclk = ~mclk;
  // a hang counts as a mismatch; the run needs about 530 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic final_report;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // rows first, then clear and simultaneous clocks
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    `CHK({pout, poe_n, cas}, 17'h001fe)
    foreach (rows[i]) begin
      u_host.send(rows[i][7:0]);
      u_host.output_enable_n = rows[i][8];
      u_host.pulse(1'b0, 1'b1);
      repeat (6) @(negedge mclk);
      `CHK(pout, rows[i][7:0])
      `CHK(poe_n, {8{rows[i][8]}})
      `CHK(cas, rows[i][7])
      $display("row %0d done", i);
    end
    u_host.shift_clear_n = 1'b0;
    u_host.send(8'hff);
    `CHK({cas, pout}, 9'h03c)
    u_host.shift_clear_n = 1'b1;
    u_host.pulse(1'b0, 1'b1);
    repeat (6) @(negedge mclk);
    `CHK(pout, 8'h00)
    $display("clear test done");
    u_host.send(8'h81);
    u_host.pulse(1'b1, 1'b1);
    repeat (6) @(negedge mclk);
    `CHK({cas, pout}, 9'h081)
    u_host.pulse(1'b0, 1'b1);
    repeat (6) @(negedge mclk);
    `CHK(pout, 8'h02)
    $display("joint clock test done");
    final_report;
  end
endmodule
bind serial_to_parallel_latch_8bit latch_properties #(.WIDTH(WIDTH)) u_props (.mclk(mclk),
  .sys_rst(sys_rst), .shift_data_in(shift_data_in), .shift_clock(shift_clock),
  .shift_clear_n(shift_clear_n), .store_clock(store_clock),
  .output_enable_n(output_enable_n), .parallel_out(parallel_out),
  .parallel_out_oe_n(parallel_out_oe_n), .cascade_out(cascade_out));
